/* File: rtl/smmd_pkg.sv */
// constants and types for the subsystem memory map decoder
// assumes one subsystem clock; all users import the whole package
package smmd_pkg;

	// ----------------------------------------------------------------
	// widths and block geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int DATA_AW = 16;
	localparam int PROG_AW = 18;
	localparam int MBUS_AW = 18;
	localparam int DUAL_ACCESS_RAM_BLOCKS = 6;
	localparam int DUAL_ACCESS_RAM_BLK_AW = 14;
	localparam int SHARED_BLOCKS = 4;
	localparam int SHARED_BLK_AW = 15;
	localparam int SHARED_AW = 17;
	localparam int BLK_IDX_W = 3;

	// ----------------------------------------------------------------
	// decode constants
	// ----------------------------------------------------------------
	localparam logic [DATA_AW-1:0] PAGE_REG_ADDR = 16'h0020;
	localparam logic [1:0] PROG_PAGE_RESERVED = 2'h3;
	localparam logic [BLK_IDX_W-1:0] UPPER_BASE_BLK = 3'h2;
	localparam int MBUS_CYCLES = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic OVERLAY_RST = 1'b0;
	localparam logic PAGE_SEL_RST = 1'b0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MB_IDLE, MB_ACC, MB_DONE} smmd_mbus_state_t;
	typedef enum logic [1:0] {SRC_NONE, SRC_DUAL_ACCESS_RAM, SRC_SHARED, SRC_ZERO} smmd_src_t;

endpackage : smmd_pkg

/* File: rtl/smmd_mem_if.sv */
// one synchronous memory port: request side and memory side
// assumes the memory answers rdata one clock after en
`timescale 1ns/1ns
interface smmd_mem_if #(
	parameter int AW = 14,
	parameter int DW = 16
) ();
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport requester (output en, output we, output addr, output wdata, input rdata);
	modport memory (input en, input we, input addr, input wdata, output rdata);
endinterface : smmd_mem_if

/* File: rtl/smmd_dual_ram.sv */
// one dual-access ram block, two full ports per cycle
// assumes the decoder never writes one word from both ports at once
`timescale 1ns/1ns
module smmd_dual_ram #(
	parameter int AW = 14,
	parameter int DW = 16
) (
	input wire logic CLK,
	input wire logic CE,
	smmd_mem_if.memory port_a,
	smmd_mem_if.memory port_b
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rd_a_q;
	logic [DW-1:0] rd_b_q;

	// ----------------------------------------------------------------
	// storage, read-before-write on each port
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (CE) begin
			if (port_b.en && port_b.we) begin
				mem[port_b.addr] <= port_b.wdata;
			end
			// port a is placed last so it wins a same-word collision
			if (port_a.en && port_a.we) begin
				mem[port_a.addr] <= port_a.wdata;
			end
			if (port_a.en) begin
				rd_a_q <= mem[port_a.addr];
			end
			if (port_b.en) begin
				rd_b_q <= mem[port_b.addr];
			end
		end
	end

	assign port_a.rdata = rd_a_q;
	assign port_b.rdata = rd_b_q;
endmodule : smmd_dual_ram

/* File: rtl/smmd_shared_ram.sv */
// program ram shared by a pair of subsystems
// port a: own fetch or dma (only dma writes); port b: partner fetch, read only
`timescale 1ns/1ns
module smmd_shared_ram #(
	parameter int AW = 17,
	parameter int DW = 16
) (
	input wire logic CLK,
	input wire logic CE,
	smmd_mem_if.memory port_a,
	smmd_mem_if.memory port_b
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rd_a_q;
	logic [DW-1:0] rd_b_q;

	// ----------------------------------------------------------------
	// storage; port b write strobe is ignored by construction
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (CE) begin
			if (port_a.en && port_a.we) begin
				mem[port_a.addr] <= port_a.wdata;
			end
			if (port_a.en) begin
				rd_a_q <= mem[port_a.addr];
			end
			if (port_b.en) begin
				rd_b_q <= mem[port_b.addr];
			end
		end
	end

	assign port_a.rdata = rd_a_q;
	assign port_b.rdata = rd_b_q;
endmodule : smmd_shared_ram

/* File: rtl/smmd_decoder.sv */
// memory map decode and arbitration for one subsystem
// assumes the partner subsystem drives the shared ram's second fetch port
`timescale 1ns/1ns
module smmd_decoder #(
	parameter int DW = smmd_pkg::DATA_W
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic MODE_STATUS_WR,
	input wire logic MODE_OVERLAY_IN,
	input wire logic PROG_REQ,
	input wire logic PROG_WE,
	input wire logic [smmd_pkg::PROG_AW-1:0] PROG_ADDR,
	input wire logic [DW-1:0] PROG_WDATA,
	output logic PROG_READY,
	output logic PROG_VALID,
	output logic [DW-1:0] PROG_RDATA,
	output logic PROG_WR_REJECT,
	input wire logic DATA_REQ,
	input wire logic DATA_WE,
	input wire logic [smmd_pkg::DATA_AW-1:0] DATA_ADDR,
	input wire logic [DW-1:0] DATA_WDATA,
	output logic DATA_VALID,
	output logic [DW-1:0] DATA_RDATA,
	input wire logic PEER_FETCH_REQ,
	input wire logic [smmd_pkg::SHARED_AW-1:0] PEER_FETCH_ADDR,
	output logic PEER_FETCH_VALID,
	output logic [DW-1:0] PEER_FETCH_RDATA,
	input wire logic MBUS_REQ,
	input wire logic MBUS_WE,
	input wire logic [smmd_pkg::MBUS_AW-1:0] MBUS_ADDR,
	input wire logic [DW-1:0] MBUS_WDATA,
	output logic MBUS_READY,
	output logic MBUS_ACK,
	output logic [DW-1:0] MBUS_RDATA,
	output logic RAM_OVERLAY_BIT,
	output logic DATA_PAGE_SELECT
);
	import smmd_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic ram_overlay_bit_q, ram_overlay_bit_d;
	logic data_page_select_reg_q, data_page_select_reg_d;
	smmd_mbus_state_t mb_state_q, mb_state_d;
	logic [MBUS_AW-1:0] mb_addr_q, mb_addr_d;
	logic mb_we_q, mb_we_d;
	logic [DW-1:0] mb_wdata_q, mb_wdata_d;
	smmd_src_t fsrc_q, fsrc_d;
	logic [BLK_IDX_W-1:0] fblk_q, fblk_d;
	logic fvalid_q, fvalid_d;
	logic reject_q, reject_d;
	logic dvalid_q, dvalid_d;
	logic dreg_q, dreg_d;
	logic dregv_q, dregv_d;
	logic [BLK_IDX_W-1:0] dblk_q, dblk_d;
	logic pvalid_q, pvalid_d;

	smmd_src_t f_src;
	logic [BLK_IDX_W-1:0] f_blk;
	logic [SHARED_AW-1:0] f_sh;
	logic stall, fetch_go, mb_acc, m_local;
	logic [BLK_IDX_W-1:0] m_blk;
	logic d_reg;
	logic [BLK_IDX_W-1:0] d_blk;
	logic sh_mb, sh_f;
	logic [DW-1:0] rd_a [DUAL_ACCESS_RAM_BLOCKS];
	logic [DW-1:0] rd_b [DUAL_ACCESS_RAM_BLOCKS];

	smmd_mem_if #(.AW(DUAL_ACCESS_RAM_BLK_AW), .DW(DW)) dp_a [DUAL_ACCESS_RAM_BLOCKS] ();
	smmd_mem_if #(.AW(DUAL_ACCESS_RAM_BLK_AW), .DW(DW)) dp_b [DUAL_ACCESS_RAM_BLOCKS] ();
	smmd_mem_if #(.AW(SHARED_AW), .DW(DW)) sh_a ();
	smmd_mem_if #(.AW(SHARED_AW), .DW(DW)) sh_b ();

	// local block index: lower half uses blocks 0-1, upper half the paged pair
	function automatic logic [BLK_IDX_W-1:0] dual_access_ram_blk(input logic upper, input logic page,
			input logic sel);
		dual_access_ram_blk = upper ? UPPER_BASE_BLK + {1'b0, page, sel} : {2'b00, sel};
	endfunction : dual_access_ram_blk

	// ----------------------------------------------------------------
	// program fetch decode
	// ----------------------------------------------------------------
	always_comb begin
		f_src = SRC_ZERO;
		f_blk = '0;
		f_sh = '0;
		if (!PROG_ADDR[SHARED_BLK_AW]) begin
			if (ram_overlay_bit_q) begin
				f_src = SRC_DUAL_ACCESS_RAM;
				f_blk = dual_access_ram_blk(1'b0, 1'b0, PROG_ADDR[DUAL_ACCESS_RAM_BLK_AW]);
			end else begin
				f_src = SRC_SHARED;
				f_sh = {PROG_PAGE_RESERVED, PROG_ADDR[SHARED_BLK_AW-1:0]};
			end
		end else if (PROG_ADDR[PROG_AW-1:PROG_AW-2] != PROG_PAGE_RESERVED) begin
			f_src = SRC_SHARED;
			f_sh = {PROG_ADDR[PROG_AW-1:PROG_AW-2], PROG_ADDR[SHARED_BLK_AW-1:0]};
		end
	end

	// the memory bus owns the fetch ports from request to completion
	assign stall = MBUS_REQ || (mb_state_q != MB_IDLE);
	assign fetch_go = PROG_REQ && !stall;
	assign PROG_READY = !stall;

	// ----------------------------------------------------------------
	// data decode
	// ----------------------------------------------------------------
	assign d_reg = (DATA_ADDR == PAGE_REG_ADDR);
	// lower half ignores the page bit
	assign d_blk = dual_access_ram_blk(DATA_ADDR[SHARED_BLK_AW], data_page_select_reg_q,
		DATA_ADDR[DUAL_ACCESS_RAM_BLK_AW]);

	// ----------------------------------------------------------------
	// memory bus decode
	// ----------------------------------------------------------------
	assign mb_acc = (mb_state_q == MB_ACC);
	assign m_local = !mb_addr_q[MBUS_AW-1];
	assign m_blk = mb_addr_q[DUAL_ACCESS_RAM_BLK_AW+BLK_IDX_W-1:DUAL_ACCESS_RAM_BLK_AW];
	assign MBUS_READY = (mb_state_q == MB_IDLE);
	assign MBUS_ACK = (mb_state_q == MB_DONE);

	// ----------------------------------------------------------------
	// dual-access ram blocks
	// ----------------------------------------------------------------
	for (genvar i = 0; i < DUAL_ACCESS_RAM_BLOCKS; i++) begin : g_dual_access_ram
		logic mb_hit, f_hit;
		assign mb_hit = mb_acc && m_local && (m_blk == BLK_IDX_W'(i));
		assign f_hit = fetch_go && (f_src == SRC_DUAL_ACCESS_RAM) && (f_blk == BLK_IDX_W'(i));
		// port a serves cpu data, port b serves fetch or dma
		assign dp_a[i].en = DATA_REQ && !d_reg && (d_blk == BLK_IDX_W'(i));
		assign dp_a[i].we = DATA_WE;
		assign dp_a[i].addr = DATA_ADDR[DUAL_ACCESS_RAM_BLK_AW-1:0];
		assign dp_a[i].wdata = DATA_WDATA;
		assign dp_b[i].en = mb_hit || f_hit;
		assign dp_b[i].we = mb_hit ? mb_we_q : PROG_WE;
		assign dp_b[i].addr = mb_hit ? mb_addr_q[DUAL_ACCESS_RAM_BLK_AW-1:0] :
			PROG_ADDR[DUAL_ACCESS_RAM_BLK_AW-1:0];
		assign dp_b[i].wdata = mb_hit ? mb_wdata_q : PROG_WDATA;
		assign rd_a[i] = dp_a[i].rdata;
		assign rd_b[i] = dp_b[i].rdata;
		smmd_dual_ram #(.AW(DUAL_ACCESS_RAM_BLK_AW), .DW(DW)) u_ram (
			.CLK(CLK),
			.CE(CE),
			.port_a(dp_a[i]),
			.port_b(dp_b[i])
		);
	end

	// ----------------------------------------------------------------
	// pair-shared program ram
	// ----------------------------------------------------------------
	assign sh_mb = mb_acc && !m_local;
	assign sh_f = fetch_go && (f_src == SRC_SHARED);
	assign sh_a.en = sh_mb || sh_f;
	assign sh_a.we = sh_mb && mb_we_q;
	assign sh_a.addr = sh_mb ? mb_addr_q[SHARED_AW-1:0] : f_sh;
	assign sh_a.wdata = mb_wdata_q;
	// partner port never waits on this side
	assign sh_b.en = PEER_FETCH_REQ;
	assign sh_b.we = 1'b0;
	assign sh_b.addr = PEER_FETCH_ADDR;
	assign sh_b.wdata = '0;

	smmd_shared_ram #(.AW(SHARED_AW), .DW(DW)) u_shared (
		.CLK(CLK),
		.CE(CE),
		.port_a(sh_a),
		.port_b(sh_b)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		ram_overlay_bit_d = ram_overlay_bit_q;
		data_page_select_reg_d = data_page_select_reg_q;
		mb_state_d = mb_state_q;
		mb_addr_d = mb_addr_q;
		mb_we_d = mb_we_q;
		mb_wdata_d = mb_wdata_q;
		if (MODE_STATUS_WR) begin
			ram_overlay_bit_d = MODE_OVERLAY_IN;
		end
		if (DATA_REQ && DATA_WE && d_reg) begin
			data_page_select_reg_d = DATA_WDATA[0];
		end
		case (mb_state_q)
			MB_IDLE: begin
				if (MBUS_REQ) begin
					mb_state_d = MB_ACC;
					mb_addr_d = MBUS_ADDR;
					mb_we_d = MBUS_WE;
					mb_wdata_d = MBUS_WDATA;
				end
			end
			MB_ACC: begin
				mb_state_d = MB_DONE;
			end
			MB_DONE: begin
				mb_state_d = MB_IDLE;
			end
			default: begin
				mb_state_d = MB_IDLE;
			end
		endcase
		fvalid_d = fetch_go && !PROG_WE;
		fsrc_d = fetch_go ? f_src : SRC_NONE;
		fblk_d = f_blk;
		reject_d = fetch_go && PROG_WE && (f_src != SRC_DUAL_ACCESS_RAM);
		dvalid_d = DATA_REQ && !DATA_WE;
		dreg_d = d_reg;
		dregv_d = data_page_select_reg_q;
		dblk_d = d_blk;
		pvalid_d = PEER_FETCH_REQ;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ram_overlay_bit_q <= OVERLAY_RST;
			data_page_select_reg_q <= PAGE_SEL_RST;
			mb_state_q <= MB_IDLE;
			mb_addr_q <= '0;
			mb_we_q <= 1'b0;
			mb_wdata_q <= '0;
			fvalid_q <= 1'b0;
			fsrc_q <= SRC_NONE;
			fblk_q <= '0;
			reject_q <= 1'b0;
			dvalid_q <= 1'b0;
			dreg_q <= 1'b0;
			dregv_q <= 1'b0;
			dblk_q <= '0;
			pvalid_q <= 1'b0;
		end else if (CE) begin
			ram_overlay_bit_q <= ram_overlay_bit_d;
			data_page_select_reg_q <= data_page_select_reg_d;
			mb_state_q <= mb_state_d;
			mb_addr_q <= mb_addr_d;
			mb_we_q <= mb_we_d;
			mb_wdata_q <= mb_wdata_d;
			fvalid_q <= fvalid_d;
			fsrc_q <= fsrc_d;
			fblk_q <= fblk_d;
			reject_q <= reject_d;
			dvalid_q <= dvalid_d;
			dreg_q <= dreg_d;
			dregv_q <= dregv_d;
			dblk_q <= dblk_d;
			pvalid_q <= pvalid_d;
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	// reads of the reserved page return zero rather than stale ram data
	always_comb begin
		case (fsrc_q)
			SRC_DUAL_ACCESS_RAM: PROG_RDATA = rd_b[fblk_q];
			SRC_SHARED: PROG_RDATA = sh_a.rdata;
			default: PROG_RDATA = '0;
		endcase
		if (!MBUS_ACK) begin
			MBUS_RDATA = '0;
		end else if (!m_local) begin
			MBUS_RDATA = sh_a.rdata;
		end else if (m_blk < BLK_IDX_W'(DUAL_ACCESS_RAM_BLOCKS)) begin
			MBUS_RDATA = rd_b[m_blk];
		end else begin
			MBUS_RDATA = '0;
		end
		DATA_RDATA = dreg_q ? {{(DW-1){1'b0}}, dregv_q} : rd_a[dblk_q];
	end

	assign PROG_VALID = fvalid_q;
	assign PROG_WR_REJECT = reject_q;
	assign DATA_VALID = dvalid_q;
	assign PEER_FETCH_VALID = pvalid_q;
	assign PEER_FETCH_RDATA = sh_b.rdata;
	assign RAM_OVERLAY_BIT = ram_overlay_bit_q;
	assign DATA_PAGE_SELECT = data_page_select_reg_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ram_overlay_bit_reset: assert property (@(posedge CLK) RST |=> !RAM_OVERLAY_BIT)
		else $error("overlay bit not cleared by reset");
	a_page_reset: assert property (@(posedge CLK) RST |=> !DATA_PAGE_SELECT)
		else $error("page select not cleared by reset");
	a_mbus_two_cyc: assert property (@(posedge CLK) disable iff (RST || !CE)
		(MBUS_READY && MBUS_REQ) |=> !MBUS_ACK ##1 MBUS_ACK ##1 MBUS_READY)
		else $error("memory bus access not two cycles");
	a_fetch_stall: assert property (@(posedge CLK) disable iff (RST || !CE)
		(MBUS_READY && MBUS_REQ) |-> !PROG_READY ##1 (!PROG_READY && !PROG_VALID)
		##1 (!PROG_READY && !PROG_VALID))
		else $error("fetch issued during memory bus transfer");
	a_shared_nowr: assert property (@(posedge CLK) disable iff (RST)
		sh_a.we |-> (mb_state_q == MB_ACC) && !sh_b.we)
		else $error("shared ram written by cpu");
	a_prog_reject: assert property (@(posedge CLK) disable iff (RST || !CE)
		(fetch_go && PROG_WE && f_src == SRC_SHARED) |=> PROG_WR_REJECT)
		else $error("shared program write not rejected");
	a_upper_page: assert property (@(posedge CLK) disable iff (RST)
		(DATA_ADDR[SHARED_BLK_AW] && !d_reg) |->
		d_blk == (DATA_PAGE_SELECT ? {2'b10, DATA_ADDR[DUAL_ACCESS_RAM_BLK_AW]} :
		{2'b01, DATA_ADDR[DUAL_ACCESS_RAM_BLK_AW]}))
		else $error("upper data decode ignores page");
	a_lower_local: assert property (@(posedge CLK) disable iff (RST)
		!DATA_ADDR[SHARED_BLK_AW] |-> d_blk == {2'b00, DATA_ADDR[DUAL_ACCESS_RAM_BLK_AW]})
		else $error("lower data not local");
	a_page_write: assert property (@(posedge CLK) disable iff (RST || !CE)
		(DATA_REQ && DATA_WE && d_reg) |=> DATA_PAGE_SELECT == $past(DATA_WDATA[0]))
		else $error("page register write lost");
	a_ram_overlay_bit_fetch: assert property (@(posedge CLK) disable iff (RST)
		(RAM_OVERLAY_BIT && !PROG_ADDR[SHARED_BLK_AW]) |-> f_src == SRC_DUAL_ACCESS_RAM)
		else $error("overlay fetch not to local ram");
	a_page3_fetch: assert property (@(posedge CLK) disable iff (RST)
		(!RAM_OVERLAY_BIT && !PROG_ADDR[SHARED_BLK_AW]) |->
		f_src == SRC_SHARED && f_sh[SHARED_AW-1:SHARED_AW-2] == 2'h3)
		else $error("fetch not sent to page three");
	a_peer_fetch: assert property (@(posedge CLK) disable iff (RST || !CE)
		PEER_FETCH_REQ |=> PEER_FETCH_VALID)
		else $error("partner fetch blocked");
endmodule : smmd_decoder

/* File: dv/smmd_mbus_host.sv */
// memory bus master model standing in for the dma engine and the host port
// assumes the decoder samples requests on the rising edge; this model moves on falling edges
`timescale 1ns/1ns
module smmd_mbus_host (
	input wire logic clk,
	input wire logic ready,
	input wire logic ack,
	input wire logic [15:0] rdata,
	output logic req,
	output logic we,
	output logic [17:0] addr,
	output logic [15:0] wdata
);
	initial begin
		req = 1'b0;
		we = 1'b0;
		addr = 18'h00000;
		wdata = 16'h0000;
	end

	// ----------------------------------------------------------------
	// one word transfer; gap idles first so the host can be slow too
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d,
			input int gap, output int lat, output logic [15:0] rd);
		int n;
		repeat (gap) @(negedge clk);
		req = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		n = 0;
		// ready and ack come from state flops, so they are settled at the falling edge
		// a request seen while busy is ignored, so hold it
		while (!ready && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		// released lines get the inverse so no stale copy looks valid
		req = 1'b0;
		we = ~w;
		addr = ~a;
		wdata = ~d;
		lat = 1;
		while (!ack && lat < 50) begin
			@(negedge clk);
			lat++;
		end
		rd = rdata;
	endtask : xfer
endmodule : smmd_mbus_host

/* File: dv/subsystem_memory_map_decoder_tb.sv */
// self-checking bench for the subsystem memory map decoder
// assumes the package constants; bus master model drives the memory bus
`timescale 1ns/1ns
module subsystem_memory_map_decoder_tb;
	import smmd_pkg::*;
	logic CLK, RST, CE, MODE_STATUS_WR, MODE_OVERLAY_IN;
	logic PROG_REQ, PROG_WE, PROG_READY, PROG_VALID, PROG_WR_REJECT;
	logic [17:0] PROG_ADDR;
	logic [15:0] PROG_WDATA, PROG_RDATA, DATA_ADDR, DATA_WDATA, DATA_RDATA;
	logic DATA_REQ, DATA_WE, DATA_VALID, PEER_FETCH_REQ, PEER_FETCH_VALID;
	logic [16:0] PEER_FETCH_ADDR;
	logic [15:0] PEER_FETCH_RDATA, MBUS_WDATA, MBUS_RDATA;
	logic MBUS_REQ, MBUS_WE, MBUS_READY, MBUS_ACK, RAM_OVERLAY_BIT, DATA_PAGE_SELECT;
	logic [17:0] MBUS_ADDR;
	int err_total = 0;
	int compares = 0;

	smmd_decoder u_smmd_decoder (.CLK(CLK), .RST(RST), .CE(CE),
		.MODE_STATUS_WR(MODE_STATUS_WR), .MODE_OVERLAY_IN(MODE_OVERLAY_IN),
		.PROG_REQ(PROG_REQ), .PROG_WE(PROG_WE), .PROG_ADDR(PROG_ADDR),
		.PROG_WDATA(PROG_WDATA), .PROG_READY(PROG_READY), .PROG_VALID(PROG_VALID),
		.PROG_RDATA(PROG_RDATA), .PROG_WR_REJECT(PROG_WR_REJECT), .DATA_REQ(DATA_REQ),
		.DATA_WE(DATA_WE), .DATA_ADDR(DATA_ADDR), .DATA_WDATA(DATA_WDATA),
		.DATA_VALID(DATA_VALID), .DATA_RDATA(DATA_RDATA), .PEER_FETCH_REQ(PEER_FETCH_REQ),
		.PEER_FETCH_ADDR(PEER_FETCH_ADDR), .PEER_FETCH_VALID(PEER_FETCH_VALID),
		.PEER_FETCH_RDATA(PEER_FETCH_RDATA), .MBUS_REQ(MBUS_REQ), .MBUS_WE(MBUS_WE),
		.MBUS_ADDR(MBUS_ADDR), .MBUS_WDATA(MBUS_WDATA), .MBUS_READY(MBUS_READY),
		.MBUS_ACK(MBUS_ACK), .MBUS_RDATA(MBUS_RDATA), .RAM_OVERLAY_BIT(RAM_OVERLAY_BIT),
		.DATA_PAGE_SELECT(DATA_PAGE_SELECT));

	smmd_mbus_host u_smmd_mbus_host (.clk(CLK), .ready(MBUS_READY), .ack(MBUS_ACK),
		.rdata(MBUS_RDATA), .req(MBUS_REQ), .we(MBUS_WE), .addr(MBUS_ADDR),
		.wdata(MBUS_WDATA));

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// ----------------------------------------------------------------
	// compare, report and access tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_bit

	task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] d,
			output logic [15:0] rd);
		int lat;
		u_smmd_mbus_host.xfer(w, a, d, 0, lat, rd);
		chk_word(16'(lat), 16'h0002, "bus latency");
		if (lat > 40)
			finish_test();
	endtask : bus

	task automatic dacc(input logic w, input logic [15:0] a, input logic [15:0] d,
			output logic [15:0] rd);
		DATA_REQ = 1'b1;
		DATA_WE = w;
		DATA_ADDR = a;
		DATA_WDATA = d;
		@(negedge CLK);
		DATA_REQ = 1'b0;
		DATA_ADDR = ~a;
		rd = DATA_RDATA;
		if (!w)
			chk_bit(DATA_VALID, 1'b1, "data valid");
		// one idle edge so a following call never re-raises the strobe in this step
		@(negedge CLK);
	endtask : dacc

	task automatic pf(input logic w, input logic [17:0] a, input logic [15:0] d,
			output logic [15:0] rd, output logic rej, output int waits);
		PROG_REQ = 1'b1;
		PROG_WE = w;
		PROG_ADDR = a;
		PROG_WDATA = d;
		waits = 0;
		#1;
		while (PROG_READY !== 1'b1) begin
			@(negedge CLK);
			#1;
			waits++;
			if (waits > 50) begin
				err_total++;
				finish_test();
			end
		end
		@(negedge CLK);
		PROG_REQ = 1'b0;
		PROG_ADDR = ~a;
		rd = PROG_RDATA;
		rej = PROG_WR_REJECT;
		if (!w)
			chk_bit(PROG_VALID, 1'b1, "fetch valid");
		@(negedge CLK);
	endtask : pf

	task automatic mode(input logic v);
		MODE_STATUS_WR = 1'b1;
		MODE_OVERLAY_IN = v;
		@(negedge CLK);
		MODE_STATUS_WR = 1'b0;
		MODE_OVERLAY_IN = ~v;
		chk_bit(RAM_OVERLAY_BIT, v, "overlay bit");
	endtask : mode

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [15:0] r;
		mode(1'b1);
		dacc(1'b1, PAGE_REG_ADDR, 16'h0001, r);
		RST = 1'b1;
		@(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		chk_bit(RAM_OVERLAY_BIT, 1'b0, "overlay after reset");
		chk_bit(DATA_PAGE_SELECT, 1'b0, "page after reset");
		chk_bit(MBUS_READY, 1'b1, "bus ready after reset");
		$display("test reset done");
	endtask : t_reset

	task automatic t_page();
		logic [15:0] r;
		bus(1'b1, 18'h08005, 16'h1111, r);
		bus(1'b1, 18'h10005, 16'h2222, r);
		bus(1'b0, 18'h08005, 16'h0000, r);
		chk_word(r, 16'h1111, "bus read");
		dacc(1'b0, 16'h8005, 16'h0000, r);
		chk_word(r, 16'h1111, "upper page 0");
		dacc(1'b1, PAGE_REG_ADDR, 16'h0001, r);
		chk_bit(DATA_PAGE_SELECT, 1'b1, "page bit");
		dacc(0, PAGE_REG_ADDR, 16'h0000, r);
		chk_word(r, 16'h0001, "page readback");
		dacc(1'b0, 16'h8005, 16'h0000, r);
		chk_word(r, 16'h2222, "upper page 1");
		dacc(1'b1, PAGE_REG_ADDR, 16'h0000, r);
		$display("test page done");
	endtask : t_page

	task automatic t_shared();
		logic [15:0] r;
		logic rej;
		int w;
		bus(1'b1, 18'h38000, 16'h3333, r);
		bus(1'b1, 18'h28000, 16'h4444, r);
		bus(1'b1, 18'h38004, 16'h6666, r);
		fork
			pf(1'b0, 18'h00000, 16'h0000, r, rej, w);
			begin
				PEER_FETCH_REQ = 1'b1;
				PEER_FETCH_ADDR = 17'h08000;
				@(negedge CLK);
				PEER_FETCH_REQ = 1'b0;
				PEER_FETCH_ADDR = 17'h17fff;
				chk_bit(PEER_FETCH_VALID, 1'b1, "peer valid");
				chk_word(PEER_FETCH_RDATA, 16'h4444, "peer data");
			end
		join
		chk_word(r, 16'h3333, "low fetch no overlay");
		pf(1'b0, 18'h18000, 16'h0000, r, rej, w);
		chk_word(r, 16'h4444, "shared fetch");
		pf(1'b1, 18'h18000, 16'hdead, r, rej, w);
		chk_bit(rej, 1'b1, "write rejected");
		pf(1'b0, 18'h18000, 16'h0000, r, rej, w);
		chk_word(r, 16'h4444, "shared unchanged");
		pf(1'b0, 18'h38000, 16'h0000, r, rej, w);
		chk_word(r, 16'h0000, "reserved page reads zero");
		$display("test shared done");
	endtask : t_shared

	task automatic t_overlay();
		logic [15:0] r;
		logic rej;
		int w;
		dacc(1'b1, 16'h0004, 16'h5555, r);
		mode(1'b1);
		pf(1'b0, 18'h20004, 16'h0000, r, rej, w);
		chk_word(r, 16'h5555, "overlay fetch");
		mode(1'b0);
		pf(1'b0, 18'h20004, 16'h0000, r, rej, w);
		chk_word(r, 16'h6666, "page 3 fetch");
		dacc(1'b0, 16'h0004, 16'h0000, r);
		chk_word(r, 16'h5555, "low data local");
		// clock enable low must freeze the overlay bit against a mode write
		CE = 1'b0;
		MODE_STATUS_WR = 1'b1;
		MODE_OVERLAY_IN = 1'b1;
		@(negedge CLK);
		chk_bit(RAM_OVERLAY_BIT, 1'b0, "overlay frozen");
		CE = 1'b1;
		MODE_STATUS_WR = 1'b0;
		@(negedge CLK);
		$display("test overlay done");
	endtask : t_overlay

	task automatic t_stall();
		logic [15:0] r;
		logic [15:0] hr;
		logic rej;
		int w;
		int lat;
		fork
			u_smmd_mbus_host.xfer(1'b0, 18'h08005, 16'h0000, 0, lat, hr);
			pf(1'b0, 18'h00000, 16'h0000, r, rej, w);
		join
		chk_word(16'(lat), 16'h0002, "bus latency under stall");
		if (lat > 40)
			finish_test();
		chk_bit(w >= 3, 1'b1, "fetch waited for bus");
		chk_word(hr, 16'h1111, "bus data under stall");
		chk_word(r, 16'h3333, "stalled fetch data");
		$display("test stall done");
	endtask : t_stall

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		RST = 1'b1;
		CE = 1'b1;
		MODE_STATUS_WR = 1'b0;
		MODE_OVERLAY_IN = 1'b0;
		PROG_REQ = 1'b0;
		PROG_WE = 1'b0;
		PROG_ADDR = 18'h00000;
		PROG_WDATA = 16'h0000;
		DATA_REQ = 1'b0;
		DATA_WE = 1'b0;
		DATA_ADDR = 16'h0000;
		DATA_WDATA = 16'h0000;
		PEER_FETCH_REQ = 1'b0;
		PEER_FETCH_ADDR = 17'h00000;
		repeat (5) @(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		chk_bit(RAM_OVERLAY_BIT, 1'b0, "overlay at start");
		t_page();
		t_shared();
		t_overlay();
		t_stall();
		t_reset();
		finish_test();
	end
endmodule : subsystem_memory_map_decoder_tb
